/* File: rtl/frs_seq.sv */
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// Contract
// - writing one to the trigger bit starts a warm fundamental reset
// - sequence waits until the reset condition has cleared
// - boot pins captured on pin release; soft reset reuses old values
// - three-bit mode decoded; code one means EEPROM initialization
// - PLL and SerDes initialized, then link training starts
// - reset-halt pin sets the halt status bit
// - non-test mode releases stacks into quasi-reset
// - links train within 20 ms of reset clearing
// - within 100 ms stacks answer configuration with retry only
// - EEPROM mode loads EEPROM contents as register writes
// - EEPROM write of full-link-retrain retrains that port
// - EEPROM error aborts load, sets halt, records error details
// - done flag set when load ends or errors
// - halt bit holds logic in reset until it clears
// - agent accesses registers and EEPROM while halted, clears halt
// - normal operation within 1 s given load within 200 ms
// - register side effects start at the EEPROM write itself
// - triggering write completes before reset begins
// - one reset output per downstream port on a GPIO
// - fundamental reset returns GPIO pins to input
// - mode 0 normal, 1 EEPROM init, higher reserved
// - pin reset is cold at power-on, warm otherwise
module frs_seq #(
    parameter int unsigned LINK_TRAIN_CYC = frs_pkg::LINK_TRAIN_CYC,
    parameter int unsigned CFG_RETRY_CYC = frs_pkg::CFG_RETRY_CYC,
    parameter int unsigned EE_LOAD_CYC = frs_pkg::EE_LOAD_CYC,
    parameter int unsigned NORMAL_OP_CYC = frs_pkg::NORMAL_OP_CYC,
    parameter int unsigned PLL_INIT_CYC = frs_pkg::PLL_INIT_CYC,
    parameter int N_DSP = 2,
    parameter int N_PORT = 3,
    parameter int TW = 24
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // boot pins
    input wire logic sys_reset_in_n,
    input wire logic [2:0] op_mode_pins,
    input wire logic reset_halt_pin,
    // phy, link and stacks
    output logic pll_serdes_init,
    output logic link_train_en,
    output logic [N_PORT-1:0] full_link_retrain,
    output logic stack_rst_n,
    output logic stack_quasi_rst,
    output logic core_rst_n,
    output logic normal_op,
    // serial eeprom master
    output logic ee_load_start,
    input wire frs_pkg::frs_ee_wr_t ee_wr,
    input wire logic ee_done,
    input wire logic ee_err,
    input wire logic [3:0] ee_err_code,
    output logic ee_acc_req,
    output logic [31:0] ee_acc_wdata,
    input wire logic [31:0] ee_acc_rdata,
    // downstream port resets on gpio
    output logic [N_DSP-1:0] dsp_rst_o,
    output logic [N_DSP-1:0] dsp_rst_oe_n
);

    // ****************************************
    // declarations
    // ****************************************
    localparam logic [TW-1:0] LINK_LIM = TW'(LINK_TRAIN_CYC);
    localparam logic [TW-1:0] RETRY_LIM = TW'(CFG_RETRY_CYC);
    localparam logic [TW-1:0] EE_LIM = TW'(EE_LOAD_CYC);
    localparam logic [TW-1:0] NORM_LIM = TW'(NORMAL_OP_CYC);
    localparam logic [TW-1:0] PLL_LIM = TW'(PLL_INIT_CYC);

    frs_pkg::frs_state_t state_r;
    frs_pkg::frs_state_t state_nxt;
    frs_pkg::frs_boot_t boot_r;
    frs_pkg::frs_boot_t boot_s;
    logic sys_rst_n_s;
    logic [TW-1:0] tmr;
    logic trig_r;
    logic ctrl_halt_r;
    logic sts_halt_r;
    logic pin_seen_r;
    logic warm_r;
    logic sbus_done_r;
    logic sbus_err_r;
    logic [3:0] sbus_code_r;
    logic [N_DSP-1:0] gpio_alt_r;
    logic [N_DSP-1:0] gpio_lvl_r;
    logic fund_cond;
    logic test_mode;
    logic apb_acc;
    logic addr_ok;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic ee_fail;

    // ****************************************
    // pin synchronisers and timer
    // ****************************************
    frs_sync #(
        .W(5)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({reset_halt_pin, op_mode_pins, sys_reset_in_n}),
        .dout({boot_s, sys_rst_n_s})
    );

    frs_tmr #(
        .TW(TW)
    ) u_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .clr(state_r == frs_pkg::ST_WAIT),
        .cnt(tmr)
    );

    // ****************************************
    // register write path
    // ****************************************
    // eeprom writes take the port; apb waits a cycle
    assign pready = ~ee_wr.valid;
    assign apb_acc = psel & penable & pready;
    always_comb begin
        case (paddr)
            frs_pkg::OFS_CTRL, frs_pkg::OFS_STS, frs_pkg::OFS_SBUS,
            frs_pkg::OFS_EEACC, frs_pkg::OFS_PHY,
            frs_pkg::OFS_GPIO: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = apb_acc & ~addr_ok;
    assign wr_en = ee_wr.valid | (apb_acc & pwrite & addr_ok);
    assign wr_addr = ee_wr.valid ? ee_wr.addr : paddr;
    assign wr_data = ee_wr.valid ? ee_wr.data : pwdata;

    // ****************************************
    // reset condition and mode
    // ****************************************
    assign fund_cond = ~sys_rst_n_s | trig_r;
    // reserved codes run as test modes
    assign test_mode = (boot_r.mode != frs_pkg::MODE_NORMAL) &&
        (boot_r.mode != frs_pkg::MODE_EE_INIT);
    assign ee_fail = ee_err | (tmr >= EE_LIM);

    // trigger taken at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_r <= 1'b0;
        end else if (wr_en && wr_addr == frs_pkg::OFS_CTRL &&
                     wr_data[frs_pkg::CTRL_TRIG_BIT]) begin
            trig_r <= 1'b1;
        end else if (state_r == frs_pkg::ST_WAIT) begin
            trig_r <= 1'b0;
        end
    end

    // first reset after power-on is cold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_r <= 1'b0;
            pin_seen_r <= 1'b1;
        end else begin
            if (fund_cond && state_r != frs_pkg::ST_WAIT) begin
                warm_r <= 1'b1;
            end
            if (!sys_rst_n_s) begin
                pin_seen_r <= 1'b1;
            end else if (state_r == frs_pkg::ST_SAMPLE) begin
                pin_seen_r <= 1'b0;
            end
        end
    end

    // capture boot pins only after power-on or a pin reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_r <= '0;
        end else if (state_r == frs_pkg::ST_SAMPLE && pin_seen_r) begin
            boot_r <= boot_s;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            frs_pkg::ST_WAIT: begin
                if (!fund_cond) begin
                    state_nxt = frs_pkg::ST_SAMPLE;
                end
            end
            frs_pkg::ST_SAMPLE: state_nxt = frs_pkg::ST_PLL;
            frs_pkg::ST_PLL: begin
                if (tmr >= PLL_LIM) begin
                    state_nxt = frs_pkg::ST_LINK;
                end
            end
            frs_pkg::ST_LINK: begin
                if (boot_r.mode == frs_pkg::MODE_EE_INIT) begin
                    state_nxt = frs_pkg::ST_LOAD;
                end else begin
                    state_nxt = frs_pkg::ST_HALT;
                end
            end
            frs_pkg::ST_LOAD: begin
                if (ee_done || ee_fail) begin
                    state_nxt = frs_pkg::ST_HALT;
                end
            end
            frs_pkg::ST_HALT: begin
                if (!ctrl_halt_r) begin
                    state_nxt = frs_pkg::ST_NORMAL;
                end
            end
            frs_pkg::ST_NORMAL: state_nxt = frs_pkg::ST_NORMAL;
            default: state_nxt = frs_pkg::ST_WAIT;
        endcase
        if (fund_cond) begin
            state_nxt = frs_pkg::ST_WAIT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= frs_pkg::ST_WAIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // halt control and status
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_halt_r <= 1'b0;
            sts_halt_r <= 1'b0;
        end else begin
            if (state_r == frs_pkg::ST_SAMPLE) begin
                // halt pin into status and control
                ctrl_halt_r <= pin_seen_r ? boot_s.halt : boot_r.halt;
                sts_halt_r <= pin_seen_r ? boot_s.halt : boot_r.halt;
            end else if (state_r == frs_pkg::ST_LOAD && !ee_done &&
                         ee_fail) begin
                ctrl_halt_r <= 1'b1;
            end else if (wr_en && wr_addr == frs_pkg::OFS_CTRL) begin
                ctrl_halt_r <= wr_data[frs_pkg::CTRL_HALT_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sbus_done_r <= 1'b0;
            sbus_err_r <= 1'b0;
            sbus_code_r <= '0;
        end else if (state_r == frs_pkg::ST_WAIT) begin
            sbus_done_r <= 1'b0;
            sbus_err_r <= 1'b0;
            sbus_code_r <= '0;
        end else if (state_r == frs_pkg::ST_LOAD) begin
            if (ee_done || ee_fail) begin
                sbus_done_r <= 1'b1;
            end
            if (!ee_done && ee_fail) begin
                sbus_err_r <= 1'b1;
                sbus_code_r <= ee_err ? ee_err_code : frs_pkg::ERR_TIMEOUT;
            end
        end
    end

    // ****************************************
    // outputs to phy, stacks, eeprom
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_serdes_init <= 1'b0;
            link_train_en <= 1'b0;
            stack_rst_n <= 1'b0;
            stack_quasi_rst <= 1'b0;
            core_rst_n <= 1'b0;
            normal_op <= 1'b0;
            ee_load_start <= 1'b0;
        end else begin
            pll_serdes_init <= (state_nxt == frs_pkg::ST_PLL);
            link_train_en <= (state_nxt >= frs_pkg::ST_LINK) &&
                (state_nxt != frs_pkg::ST_WAIT);
            stack_rst_n <= !test_mode && (state_nxt >= frs_pkg::ST_LINK);
            stack_quasi_rst <= !test_mode &&
                (state_nxt >= frs_pkg::ST_LINK) &&
                (state_nxt != frs_pkg::ST_NORMAL);
            core_rst_n <= (state_nxt == frs_pkg::ST_NORMAL);
            normal_op <= (state_nxt == frs_pkg::ST_NORMAL);
            ee_load_start <= (state_r == frs_pkg::ST_LINK) &&
                (state_nxt == frs_pkg::ST_LOAD);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_link_retrain <= '0;
        end else if (wr_en && wr_addr == frs_pkg::OFS_PHY) begin
            full_link_retrain <= wr_data[N_PORT-1:0];
        end else begin
            full_link_retrain <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ee_acc_req <= 1'b0;
            ee_acc_wdata <= frs_pkg::REG_RST;
        end else begin
            ee_acc_req <= wr_en && wr_addr == frs_pkg::OFS_EEACC;
            if (wr_en && wr_addr == frs_pkg::OFS_EEACC) begin
                ee_acc_wdata <= wr_data;
            end
        end
    end

    // ****************************************
    // downstream port resets
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_alt_r <= '0;
            gpio_lvl_r <= '0;
        // gpio back to input on reset
        end else if (state_r == frs_pkg::ST_WAIT) begin
            gpio_alt_r <= '0;
            gpio_lvl_r <= '0;
        end else if (wr_en && wr_addr == frs_pkg::OFS_GPIO) begin
            gpio_alt_r <= wr_data[N_DSP-1:0];
            gpio_lvl_r <= wr_data[frs_pkg::GPIO_LVL_LSB +: N_DSP];
        end
    end

    for (genvar i = 0; i < N_DSP; i++) begin : g_dsp
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dsp_rst_o[i] <= 1'b0;
                dsp_rst_oe_n[i] <= 1'b1;
            end else begin
                dsp_rst_o[i] <= gpio_lvl_r[i];
                dsp_rst_oe_n[i] <= ~gpio_alt_r[i];
            end
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        prdata = '0;
        case (paddr)
            frs_pkg::OFS_CTRL: begin
                prdata[frs_pkg::CTRL_TRIG_BIT] = trig_r;
                prdata[frs_pkg::CTRL_HALT_BIT] = ctrl_halt_r;
            end
            frs_pkg::OFS_STS: begin
                prdata[frs_pkg::STS_HALT_BIT] = sts_halt_r;
                prdata[frs_pkg::STS_MODE_LSB +: 3] = boot_r.mode;
                prdata[frs_pkg::STS_STATE_LSB +: 3] = state_r;
                prdata[frs_pkg::STS_WARM_BIT] = warm_r;
                prdata[frs_pkg::STS_NORMAL_BIT] = normal_op;
            end
            frs_pkg::OFS_SBUS: begin
                prdata[frs_pkg::SBUS_DONE_BIT] = sbus_done_r;
                prdata[frs_pkg::SBUS_ERR_BIT] = sbus_err_r;
                prdata[frs_pkg::SBUS_CODE_LSB +: 4] = sbus_code_r;
            end
            frs_pkg::OFS_EEACC: prdata = ee_acc_rdata;
            frs_pkg::OFS_GPIO: begin
                prdata[N_DSP-1:0] = gpio_alt_r;
                prdata[frs_pkg::GPIO_LVL_LSB +: N_DSP] = gpio_lvl_r;
            end
            default: prdata = '0;
        endcase
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_trig_entry: assert property (
        $rose(trig_r) |=> state_r == frs_pkg::ST_WAIT ##1 !trig_r)
        else $error("trigger did not start reset");
    chk_wait_hold: assert property (
        !sys_rst_n_s |=> state_r == frs_pkg::ST_WAIT)
        else $error("left wait while pin reset held");
    chk_boot_keep: assert property (
        state_r == frs_pkg::ST_SAMPLE && !pin_seen_r |=> $stable(boot_r))
        else $error("boot values changed on soft reset");
    chk_ee_start: assert property (
        state_r == frs_pkg::ST_LINK && !fund_cond &&
        boot_r.mode == frs_pkg::MODE_EE_INIT |=> ee_load_start)
        else $error("eeprom load not started");
    chk_link_limit: assert property (
        tmr >= LINK_LIM && state_r != frs_pkg::ST_WAIT |-> link_train_en)
        else $error("link training late");
    chk_retry_limit: assert property (
        tmr >= RETRY_LIM && !test_mode && state_r != frs_pkg::ST_WAIT
        |-> stack_quasi_rst || normal_op)
        else $error("stacks not answering by deadline");
    chk_err_halt: assert property (
        state_r == frs_pkg::ST_LOAD && ee_err && !ee_done && !fund_cond
        |=> ctrl_halt_r && sbus_done_r && sbus_err_r)
        else $error("load error not recorded");
    chk_halt_hold: assert property (
        state_r == frs_pkg::ST_HALT && ctrl_halt_r && !fund_cond
        |-> !core_rst_n [*2])
        else $error("core released while halted");
    chk_retrain_now: assert property (
        ee_wr.valid && ee_wr.addr == frs_pkg::OFS_PHY
        |=> full_link_retrain == $past(ee_wr.data[N_PORT-1:0]))
        else $error("retrain not started at write");
    chk_gpio_float: assert property (
        state_r == frs_pkg::ST_WAIT |=> ##1 &dsp_rst_oe_n)
        else $error("gpio still driving after reset");
    chk_normal_limit: assert property (
        tmr >= NORM_LIM && !ctrl_halt_r && !fund_cond &&
        state_r != frs_pkg::ST_WAIT |-> ##[0:2] normal_op)
        else $error("normal operation late");

    cov_soft_reset: cover property ($rose(trig_r) ##[1:20] normal_op);
    cov_ee_load: cover property (ee_load_start ##[1:50] sbus_done_r);
    cov_halt_exit: cover property (
        state_r == frs_pkg::ST_HALT ##1 state_r == frs_pkg::ST_NORMAL);

endmodule // frs_seq

/* File: rtl/frs_pkg.sv */
package frs_pkg;

    // ****************************************
    // clock and time
    // ****************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned LINK_TRAIN_MS = 20;
    localparam int unsigned CFG_RETRY_MS = 100;
    localparam int unsigned EE_LOAD_MS = 200;
    localparam int unsigned NORMAL_OP_S = 1;
    localparam int unsigned PLL_INIT_US = 50;
    // longest times round down, least times round up
    localparam int unsigned LINK_TRAIN_CYC = LINK_TRAIN_MS * CYC_PER_MS;
    localparam int unsigned CFG_RETRY_CYC = CFG_RETRY_MS * CYC_PER_MS;
    localparam int unsigned EE_LOAD_CYC = EE_LOAD_MS * CYC_PER_MS;
    localparam int unsigned NORMAL_OP_CYC = NORMAL_OP_S * CLK_HZ;
    localparam int unsigned PLL_INIT_CYC =
        (PLL_INIT_US * (CLK_HZ / 1000) + 999) / 1000;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STS = 8'h04;
    localparam logic [7:0] OFS_SBUS = 8'h08;
    localparam logic [7:0] OFS_EEACC = 8'h0c;
    localparam logic [7:0] OFS_PHY = 8'h10;
    localparam logic [7:0] OFS_GPIO = 8'h14;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int unsigned CTRL_TRIG_BIT = 0;
    localparam int unsigned CTRL_HALT_BIT = 1;
    localparam int unsigned STS_HALT_BIT = 0;
    localparam int unsigned STS_MODE_LSB = 1;
    localparam int unsigned STS_STATE_LSB = 4;
    localparam int unsigned STS_WARM_BIT = 7;
    localparam int unsigned STS_NORMAL_BIT = 8;
    localparam int unsigned SBUS_DONE_BIT = 0;
    localparam int unsigned SBUS_ERR_BIT = 1;
    localparam int unsigned SBUS_CODE_LSB = 4;
    localparam int unsigned GPIO_LVL_LSB = 4;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [3:0] ERR_TIMEOUT = 4'hf;

    // ****************************************
    // modes, states, carriers
    // ****************************************
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_EE_INIT = 3'h1;

    typedef enum logic [2:0] {
        ST_WAIT = 3'h0,
        ST_SAMPLE = 3'h1,
        ST_PLL = 3'h2,
        ST_LINK = 3'h3,
        ST_LOAD = 3'h4,
        ST_HALT = 3'h5,
        ST_NORMAL = 3'h6
    } frs_state_t;

    typedef struct packed {
        logic halt;
        logic [2:0] mode;
    } frs_boot_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [31:0] data;
    } frs_ee_wr_t;

endpackage

/* File: rtl/frs_sync.sv */
`timescale 1ns/1ps
module frs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins in, filtered out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change counts once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dout[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
                dout[i] <= s3_r[i];
            end
        end
    end

endmodule // frs_sync

/* File: rtl/frs_tmr.sv */
`timescale 1ns/1ps
module frs_tmr #(
    parameter int TW = 24
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control and count
    input wire logic clr,
    output logic [TW-1:0] cnt
);

    // saturating count of cycles since clr fell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (clr) begin
            cnt <= '0;
        end else if (cnt != {TW{1'b1}}) begin
            cnt <= cnt + TW'(1);
        end
    end

endmodule // frs_tmr

/* File: verif/frs_partner.sv */
`timescale 1ns/1ps
module frs_partner (
    // clock, reset, bench knobs
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_rst,
    input wire logic fail,
    // eeprom side
    input wire logic ee_load_start,
    input wire logic ee_acc_req,
    input wire logic [31:0] ee_acc_wdata,
    output frs_pkg::frs_ee_wr_t ee_wr,
    output logic ee_done,
    output logic ee_err,
    output logic [3:0] ee_err_code,
    output logic [31:0] ee_acc_rdata,
    output logic sys_reset_in_n
);
    logic [3:0] st_r;
    assign sys_reset_in_n = !pin_rst;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= 4'h0;
            ee_wr <= '0;
            ee_done <= 1'b0;
            ee_err <= 1'b0;
            ee_err_code <= 4'h0;
            ee_acc_rdata <= 32'h0;
        end else begin
            st_r <= ee_load_start ? 4'h1 :
                (st_r == 4'h0 ? 4'h0 : st_r + 4'h1);
            ee_wr <= '{1'b0, ~ee_wr.addr, ~ee_wr.data};
            ee_done <= 1'b0;
            ee_err <= 1'b0;
            if (st_r == 4'h2)
                ee_wr <= '{1'b1, frs_pkg::OFS_GPIO, 32'h3};
            if (st_r == 4'h5)
                ee_wr <= '{1'b1, frs_pkg::OFS_PHY, 32'h2};
            if (st_r == 4'h9) begin
                ee_done <= !fail;
                ee_err <= fail;
                ee_err_code <= 4'h3;
                st_r <= 4'h0;
            end
            if (ee_acc_req)
                ee_acc_rdata <= ee_acc_wdata;
        end
    end
endmodule // frs_partner

/* File: verif/frs_seq_tb_top.sv */
`timescale 1ns/1ps
module frs_seq_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic pin_rst, fail;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, acc_wd, acc_rd, seed, d;
    logic [2:0] op_mode_pins, flr;
    logic halt_pin, rst_in_n, pll, lte, srn, sq, crn, nop, ls, done, err, acq;
    logic [3:0] code;
    logic [1:0] dso, oe_n;
    frs_pkg::frs_ee_wr_t ee_wr;
    logic [64:0] exp_q[$];
    int bad_count, n_compared, cyc, i;
    frs_seq #(.LINK_TRAIN_CYC(40), .CFG_RETRY_CYC(60), .EE_LOAD_CYC(100),
        .NORMAL_OP_CYC(200), .PLL_INIT_CYC(8)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_reset_in_n(rst_in_n),
        .op_mode_pins(op_mode_pins), .reset_halt_pin(halt_pin),
        .pll_serdes_init(pll), .link_train_en(lte), .full_link_retrain(flr),
        .stack_rst_n(srn), .stack_quasi_rst(sq), .core_rst_n(crn),
        .normal_op(nop), .ee_load_start(ls), .ee_wr(ee_wr), .ee_done(done),
        .ee_err(err), .ee_err_code(code), .ee_acc_req(acq),
        .ee_acc_wdata(acc_wd), .ee_acc_rdata(acc_rd), .dsp_rst_o(dso),
        .dsp_rst_oe_n(oe_n));
    frs_partner far (.pclk(pclk), .presetn(presetn), .pin_rst(pin_rst),
        .fail(fail), .ee_load_start(ls), .ee_acc_req(acq),
        .ee_acc_wdata(acc_wd), .ee_wr(ee_wr), .ee_done(done), .ee_err(err),
        .ee_err_code(code), .ee_acc_rdata(acc_rd), .sys_reset_in_n(rst_in_n));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic cmp_ok(input logic ok);
        n_compared++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t output level wrong", $time);
        end
    endtask
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t read got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
        input logic [32:0] e);
        exp_q.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    logic [64:0] e;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test;
        end
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            cmp_rd({pslverr, prdata & e[64:33]}, e[32:0]);
        end
    end
    initial begin
        seed = 32'h14ec488f;
        {psel, penable, pwrite, paddr, pwdata, fail, halt_pin} = '0;
        pin_rst = 1'b1;
        op_mode_pins = 3'h1;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        cmp_ok(lte === 1'b0);
        pin_rst <= 1'b0;
        for (i = 0; i < 40 && pll !== 1'b1; i++) @(posedge pclk);
        cmp_ok(pll === 1'b1 && lte === 1'b0);
        for (i = 0; i < 40 && lte !== 1'b1; i++) @(posedge pclk);
        cmp_ok(lte === 1'b1);
        for (i = 0; i < 60 && flr !== 3'h2; i++) @(posedge pclk);
        cmp_ok(flr === 3'h2 && srn === 1'b1 && sq === 1'b1);
        for (i = 0; i < 300 && nop !== 1'b1; i++) @(posedge pclk);
        cmp_ok(nop === 1'b1 && oe_n === 2'b00);
        rd(frs_pkg::OFS_SBUS, 32'h3, 33'h1);
        rd(frs_pkg::OFS_STS, 32'h18f, 33'h102);
        rd(8'h40, 32'h0, {1'b1, 32'h0});
        d = $random(seed);
        apb(1'b1, frs_pkg::OFS_EEACC, d);
        rd(frs_pkg::OFS_EEACC, 32'hffffffff, {1'b0, d});
        apb(1'b1, frs_pkg::OFS_GPIO, 32'h31);
        @(posedge pclk);
        cmp_ok(dso === 2'b11 && oe_n === 2'b10);
        op_mode_pins <= 3'h0;
        fail <= 1'b1;
        apb(1'b1, frs_pkg::OFS_CTRL, 32'h1);
        cmp_ok(nop === 1'b1);
        repeat (3) @(posedge pclk);
        cmp_ok(oe_n === 2'b11 && crn === 1'b0);
        rd(frs_pkg::OFS_CTRL, 32'h1, 33'h0);
        for (i = 0; i < 60 && ls !== 1'b1; i++) @(posedge pclk);
        cmp_ok(ls === 1'b1);
        repeat (20) @(posedge pclk);
        rd(frs_pkg::OFS_CTRL, 32'h2, 33'h2);
        rd(frs_pkg::OFS_SBUS, 32'hf3, 33'h33);
        cmp_ok(crn === 1'b0 && sq === 1'b1);
        apb(1'b1, frs_pkg::OFS_CTRL, 32'h0);
        for (i = 0; i < 20 && nop !== 1'b1; i++) @(posedge pclk);
        cmp_ok(nop === 1'b1);
        halt_pin <= 1'b1;
        pin_rst <= 1'b1;
        repeat (10) @(posedge pclk);
        cmp_ok(lte === 1'b0 && oe_n === 2'b11 && nop === 1'b0);
        pin_rst <= 1'b0;
        repeat (40) @(posedge pclk);
        rd(frs_pkg::OFS_STS, 32'h1ff, 33'hd1);
        cmp_ok(ls === 1'b0 && srn === 1'b1 && crn === 1'b0);
        apb(1'b1, frs_pkg::OFS_CTRL, 32'h0);
        for (i = 0; i < 20 && nop !== 1'b1; i++) @(posedge pclk);
        cmp_ok(nop === 1'b1 && oe_n === 2'b11);
        finish_test;
    end
endmodule // frs_seq_tb_top
